/* common/ceo_cfg.svh */
// Offsets, field positions, reset values and counts of the output enable control block
`ifndef CEO_CFG_SVH
`define CEO_CFG_SVH

// ==========================================================
// Register offsets (byte addresses)
`define CEO_OFS_MAP0 8'h00
`define CEO_OFS_MAP1 8'h04
`define CEO_OFS_MAP2 8'h08
`define CEO_OFS_OUT_EN 8'h0c
`define CEO_OFS_DIS_HIGH 8'h10
`define CEO_OFS_SYNC_DIS 8'h14
`define CEO_OFS_SE_MODE 8'h18
`define CEO_OFS_SE_INV 8'h1c
`define CEO_OFS_DRIVE 8'h20
`define CEO_OFS_LOOP_SEL 8'h24
`define CEO_OFS_CTRL 8'h28
`define CEO_OFS_PWR_DOWN 8'h2c
`define CEO_OFS_STATUS 8'h30
`define CEO_OFS_DIV_HALF 8'h34

// ==========================================================
// Control register bit positions
`define CEO_CTRL_LOL_DIS 0
`define CEO_CTRL_XTAL_KEEP 1
`define CEO_CTRL_HARD_RST 2
`define CEO_CTRL_NVM_BURN 3
`define CEO_CTRL_SPI_3W 4

// Power down register field bases
`define CEO_PD_OUT_LSB 0
`define CEO_PD_LOOP_LSB 8
`define CEO_PD_IN_LSB 12

// ==========================================================
// Reset values
`define CEO_MAP0_RST 7'h7f
`define CEO_MAP_OTHER_RST 7'h00
`define CEO_OUT_EN_RST 7'h7f
`define CEO_DIS_HIGH_RST 7'h00
`define CEO_SYNC_DIS_RST 7'h7f
`define CEO_SE_MODE_RST 7'h00
`define CEO_SE_INV_RST 7'h00
`define CEO_DRIVE_RST 14'h3fff
`define CEO_LOOP_SEL_RST 14'h0000
`define CEO_DIV_HALF_RST 8'h04

// ==========================================================
// NVM slot count and no-loop select code
`define CEO_NVM_SLOTS 2'h2
`define CEO_LOOP_NONE 2'h3

`endif

/* common/ceo_pkg.sv */
// Types of the output enable control block
package ceo_pkg;

  // ==========================================================
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ceo_bus_req_t;

  // Power down controls handed to the analog side
  typedef struct packed {
    logic [6:0] out_pd;
    logic [2:0] loop_pd;
    logic [2:0] in_pd;
  } ceo_pd_t;

  // ==========================================================
  // Configuration image, also the unit stored in NVM
  typedef struct packed {
    logic [6:0] map0;
    logic [6:0] map1;
    logic [6:0] map2;
    logic [6:0] out_en;
    logic [6:0] dis_high;
    logic [6:0] sync_dis;
    logic [6:0] se_mode;
    logic [6:0] se_inv;
    logic [13:0] drive;
    logic [13:0] loop_sel;
    logic lol_dis;
    logic xtal_keep;
    logic spi_3w;
    ceo_pd_t pd;
    logic [7:0] div_half;
  } ceo_cfg_t;

  // Start-up sequence, one-hot
  typedef enum logic [2:0] {
    CEO_LOAD = 3'b001,
    CEO_DIVRST = 3'b010,
    CEO_RUN = 3'b100
  } ceo_seq_t;

  // ==========================================================
  // Whole state of the block
  typedef struct packed {
    ceo_cfg_t cfg;
    ceo_cfg_t [1:0] nvm;
    logic [1:0] nvm_cnt;
    ceo_seq_t seq;
    logic [6:0][7:0] cnt;
    logic [6:0] phase;
    logic [6:0] active;
    logic [6:0] out_true;
    logic [6:0] out_comp;
    logic [31:0] rdata;
    logic i2c_sel;
  } ceo_state_t;

endpackage

/* rtl/ceo_output_enable.sv */
// Clock output enable, disable and start-up control with register port
// Operation
// - Three enable pins map to any outputs
// - Default: pin zero maps all, others none
// - Register disable overrides pin enable
// - Default register enables leave pins in control
// - Optional disable of outputs on lock loss
// - Crystal loss disables outputs unless kept running
// - Per-output disabled level low or high
// - Synchronous disable waits for period end
// - Asynchronous disable stops output at once
// - Single-ended drives both pins, default in phase
// - Single-ended polarity is configurable
// - Dividers reset during power-up initialisation
// - Reset pin or hard reset bit re-initialises
// - Drive select takes settings one to three
// - Any output may be single-ended
// - Power-up loads defaults from NVM
// - NVM takes two writes, latest only
// - Select pin picks I2C or SPI, SPI wire mode
// - Inputs, outputs, loops individually power down
// - Loop lock-lost indication reported
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ceo_cfg.svh"

module ceo_output_enable #(
  parameter logic [7:0] DIV_HALF_DEF = `CEO_DIV_HALF_RST
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire ceo_pkg::ceo_bus_req_t bus_i,
  output logic [31:0] reg_rdata_o,
  input wire logic enable_pin_zero_n_i,
  input wire logic enable_pin_one_n_i,
  input wire logic enable_pin_two_n_i,
  input wire logic [2:0] lock_lost_i,
  input wire logic crystal_signal_loss_i,
  input wire logic device_reset_pin_n_i,
  input wire logic serial_if_select_i,
  output logic [6:0] clock_output_true_o,
  output logic [6:0] clock_output_complement_o,
  output logic [13:0] single_ended_drive_select_o,
  output ceo_pkg::ceo_pd_t power_down_o,
  output logic i2c_selected_o,
  output logic spi_three_wire_o,
  output logic config_ready_o
);
  import ceo_pkg::*;

  // ==========================================================
  // Default configuration used before any NVM write
  localparam ceo_cfg_t CFG_DEF = '{
    map0: `CEO_MAP0_RST,
    map1: `CEO_MAP_OTHER_RST,
    map2: `CEO_MAP_OTHER_RST,
    out_en: `CEO_OUT_EN_RST,
    dis_high: `CEO_DIS_HIGH_RST,
    sync_dis: `CEO_SYNC_DIS_RST,
    se_mode: `CEO_SE_MODE_RST,
    se_inv: `CEO_SE_INV_RST,
    drive: `CEO_DRIVE_RST,
    loop_sel: `CEO_LOOP_SEL_RST,
    lol_dis: 1'b0,
    xtal_keep: 1'b0,
    spi_3w: 1'b0,
    pd: '0,
    div_half: DIV_HALF_DEF
  };

  localparam ceo_state_t ST_RST = '{
    cfg: CFG_DEF,
    nvm: {CFG_DEF, CFG_DEF},
    nvm_cnt: 2'h0,
    seq: CEO_LOAD,
    cnt: '0,
    phase: 7'h00,
    active: 7'h00,
    out_true: 7'h00,
    out_comp: 7'h7f,
    rdata: 32'h0000_0000,
    i2c_sel: 1'b0
  };

  ceo_state_t st_reg;
  ceo_state_t st_next;

  // ==========================================================
  // Next-state logic
  always_comb begin
    ceo_cfg_t loaded;
    logic [3:0] lol_vec;
    logic [1:0] lsel;
    logic pin_ok;
    logic lol_hit;
    logic xtal_hit;
    logic want;
    logic boundary;
    logic tru;
    logic hard_rst;
    loaded = CFG_DEF;
    lol_vec = {1'b0, lock_lost_i};
    lsel = 2'h0;
    pin_ok = 1'b0;
    lol_hit = 1'b0;
    xtal_hit = 1'b0;
    want = 1'b0;
    boundary = 1'b0;
    tru = 1'b0;
    hard_rst = 1'b0;
    st_next = st_reg;
    // Select pin is sampled continuously
    st_next.i2c_sel = serial_if_select_i;

    // Only the newest NVM image is reachable
    if (st_reg.nvm_cnt != 2'h0) begin
      loaded = st_reg.nvm[st_reg.nvm_cnt - 2'h1];
    end

    // Crystal loss forces outputs off unless kept running
    xtal_hit = crystal_signal_loss_i && !st_reg.cfg.xtal_keep;

    case (st_reg.seq)
      CEO_LOAD: begin
        st_next.cfg = loaded;
        st_next.active = 7'h00;
        st_next.seq = CEO_DIVRST;
      end
      CEO_DIVRST: begin
        // All dividers start together so phases line up
        st_next.cnt = '0;
        st_next.phase = 7'h00;
        st_next.active = 7'h00;
        st_next.seq = CEO_RUN;
      end
      CEO_RUN: begin
        for (int i = 0; i < 7; i++) begin
          // Board drives a pin low to enable its outputs
          pin_ok = !(st_reg.cfg.map0[i] && enable_pin_zero_n_i) &&
                   !(st_reg.cfg.map1[i] && enable_pin_one_n_i) &&
                   !(st_reg.cfg.map2[i] && enable_pin_two_n_i);
          lsel = st_reg.cfg.loop_sel[2*i +: 2];
          lol_hit = st_reg.cfg.lol_dis && (lsel != `CEO_LOOP_NONE) &&
                    lol_vec[lsel];
          want = pin_ok && st_reg.cfg.out_en[i] && !st_reg.cfg.pd.out_pd[i] &&
                 !lol_hit && !xtal_hit;
          boundary = (st_reg.cnt[i] == 8'h00) && !st_reg.phase[i];
          // Free-running half-period divider
          if (st_reg.cnt[i] == 8'h00) begin
            st_next.cnt[i] = st_reg.cfg.div_half - 8'h01;
            st_next.phase[i] = !st_reg.phase[i];
          end else begin
            st_next.cnt[i] = st_reg.cnt[i] - 8'h01;
          end
          // Turn on only at a period start; sync turn-off waits for it too
          if (boundary) begin
            st_next.active[i] = want;
          end else if (!want && !st_reg.cfg.sync_dis[i]) begin
            st_next.active[i] = 1'b0;
          end
        end
      end
      default: begin
        st_next.seq = CEO_LOAD;
      end
    endcase

    // Pin level: running clock or the chosen idle level
    for (int i = 0; i < 7; i++) begin
      tru = st_next.active[i] ? st_next.phase[i] : st_reg.cfg.dis_high[i];
      st_next.out_true[i] = tru;
      if (st_reg.cfg.se_mode[i]) begin
        st_next.out_comp[i] = tru ^ st_reg.cfg.se_inv[i];
      end else begin
        st_next.out_comp[i] = !tru;
      end
    end

    // Register writes; a load in the same cycle wins
    if (bus_i.wr && st_reg.seq != CEO_LOAD) begin
      case (bus_i.addr)
        `CEO_OFS_MAP0: st_next.cfg.map0 = bus_i.wdata[6:0];
        `CEO_OFS_MAP1: st_next.cfg.map1 = bus_i.wdata[6:0];
        `CEO_OFS_MAP2: st_next.cfg.map2 = bus_i.wdata[6:0];
        `CEO_OFS_OUT_EN: st_next.cfg.out_en = bus_i.wdata[6:0];
        `CEO_OFS_DIS_HIGH: st_next.cfg.dis_high = bus_i.wdata[6:0];
        `CEO_OFS_SYNC_DIS: st_next.cfg.sync_dis = bus_i.wdata[6:0];
        `CEO_OFS_SE_MODE: st_next.cfg.se_mode = bus_i.wdata[6:0];
        `CEO_OFS_SE_INV: st_next.cfg.se_inv = bus_i.wdata[6:0];
        `CEO_OFS_DRIVE: begin
          // A code of zero is not a valid strength and is ignored
          for (int i = 0; i < 7; i++) begin
            if (bus_i.wdata[2*i +: 2] != 2'h0) begin
              st_next.cfg.drive[2*i +: 2] = bus_i.wdata[2*i +: 2];
            end
          end
        end
        `CEO_OFS_LOOP_SEL: st_next.cfg.loop_sel = bus_i.wdata[13:0];
        `CEO_OFS_CTRL: begin
          st_next.cfg.lol_dis = bus_i.wdata[`CEO_CTRL_LOL_DIS];
          st_next.cfg.xtal_keep = bus_i.wdata[`CEO_CTRL_XTAL_KEEP];
          st_next.cfg.spi_3w = bus_i.wdata[`CEO_CTRL_SPI_3W];
          hard_rst = bus_i.wdata[`CEO_CTRL_HARD_RST];
          // Burn stores the settings as they stood before this write
          if (bus_i.wdata[`CEO_CTRL_NVM_BURN] && st_reg.nvm_cnt < `CEO_NVM_SLOTS) begin
            st_next.nvm[st_reg.nvm_cnt[0]] = st_reg.cfg;
            st_next.nvm_cnt = st_reg.nvm_cnt + 2'h1;
          end
        end
        `CEO_OFS_PWR_DOWN: begin
          st_next.cfg.pd.out_pd = bus_i.wdata[`CEO_PD_OUT_LSB +: 7];
          st_next.cfg.pd.loop_pd = bus_i.wdata[`CEO_PD_LOOP_LSB +: 3];
          st_next.cfg.pd.in_pd = bus_i.wdata[`CEO_PD_IN_LSB +: 3];
        end
        `CEO_OFS_DIV_HALF: st_next.cfg.div_half = bus_i.wdata[7:0];
        default: begin
        end
      endcase
    end

    // Reset pin or hard reset bit restarts from the NVM load
    if (!device_reset_pin_n_i || hard_rst) begin
      st_next.seq = CEO_LOAD;
    end

    // Read data stands in the cycle after the strobe only
    st_next.rdata = 32'h0000_0000;
    if (bus_i.rd) begin
      case (bus_i.addr)
        `CEO_OFS_MAP0: st_next.rdata = {25'h0, st_reg.cfg.map0};
        `CEO_OFS_MAP1: st_next.rdata = {25'h0, st_reg.cfg.map1};
        `CEO_OFS_MAP2: st_next.rdata = {25'h0, st_reg.cfg.map2};
        `CEO_OFS_OUT_EN: st_next.rdata = {25'h0, st_reg.cfg.out_en};
        `CEO_OFS_DIS_HIGH: st_next.rdata = {25'h0, st_reg.cfg.dis_high};
        `CEO_OFS_SYNC_DIS: st_next.rdata = {25'h0, st_reg.cfg.sync_dis};
        `CEO_OFS_SE_MODE: st_next.rdata = {25'h0, st_reg.cfg.se_mode};
        `CEO_OFS_SE_INV: st_next.rdata = {25'h0, st_reg.cfg.se_inv};
        `CEO_OFS_DRIVE: st_next.rdata = {18'h0, st_reg.cfg.drive};
        `CEO_OFS_LOOP_SEL: st_next.rdata = {18'h0, st_reg.cfg.loop_sel};
        `CEO_OFS_CTRL: st_next.rdata = {27'h0, st_reg.cfg.spi_3w, 2'h0,
                                        st_reg.cfg.xtal_keep, st_reg.cfg.lol_dis};
        `CEO_OFS_PWR_DOWN: st_next.rdata = {17'h0, st_reg.cfg.pd.in_pd, 1'b0,
                                            st_reg.cfg.pd.loop_pd, 1'b0,
                                            st_reg.cfg.pd.out_pd};
        // Live view: active outputs, lock lost, crystal loss, NVM use, port
        `CEO_OFS_STATUS: st_next.rdata = {11'h0, st_reg.i2c_sel, 2'h0, st_reg.nvm_cnt,
                                          3'h0, crystal_signal_loss_i, 1'b0,
                                          lock_lost_i, 1'b0, st_reg.active};
        `CEO_OFS_DIV_HALF: st_next.rdata = {24'h0, st_reg.cfg.div_half};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flops
  assign reg_rdata_o = st_reg.rdata;
  assign clock_output_true_o = st_reg.out_true;
  assign clock_output_complement_o = st_reg.out_comp;
  assign single_ended_drive_select_o = st_reg.cfg.drive;
  assign power_down_o = st_reg.cfg.pd;
  assign i2c_selected_o = st_reg.i2c_sel;
  assign spi_three_wire_o = st_reg.cfg.spi_3w;
  assign config_ready_o = st_reg.seq[2]; // One-hot bit of the run state, no gate after the flop

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_init;
    st_reg.seq == CEO_DIVRST ##1 st_reg.seq == CEO_RUN;
  endsequence

  sequence s_run_async0;
    st_reg.seq == CEO_RUN && !st_reg.cfg.sync_dis[0];
  endsequence

  a_init_order: assert property (
    (st_reg.seq == CEO_LOAD && device_reset_pin_n_i && !bus_i.wr) |=> s_init)
    else $error("start-up sequence out of order");

  a_pin_reset: assert property (
    (!device_reset_pin_n_i ##1 device_reset_pin_n_i) |-> st_reg.seq == CEO_LOAD ##1
    st_reg.seq == CEO_DIVRST ##1 (st_reg.cnt == '0 && st_reg.phase == 7'h00))
    else $error("reset pin did not restart");

  a_pin_disable: assert property (
    (s_run_async0 and (st_reg.cfg.map0[0] && enable_pin_zero_n_i)) |=> !st_reg.active[0])
    else $error("mapped high pin left output on");

  a_reg_disable: assert property (
    (s_run_async0 and !st_reg.cfg.out_en[0]) |=> !st_reg.active[0])
    else $error("register disable ignored");

  a_xtal_force: assert property (
    (s_run_async0 and (crystal_signal_loss_i && !st_reg.cfg.xtal_keep))
    |=> !st_reg.active[0] && clock_output_true_o[0] == $past(st_reg.cfg.dis_high[0]))
    else $error("crystal loss did not disable");

  a_lol_force: assert property (
    (s_run_async0 and (st_reg.cfg.lol_dis && st_reg.cfg.loop_sel[1:0] == 2'h0 &&
     lock_lost_i[0])) |=> !st_reg.active[0])
    else $error("lock loss did not disable");

  a_sync_no_runt: assert property (
    ($fell(st_reg.active[0]) && $past(st_reg.seq) == CEO_RUN &&
     $past(st_reg.cfg.sync_dis[0])) |-> ($past(st_reg.cnt[0]) == 8'h00 &&
     !$past(st_reg.phase[0])))
    else $error("sync disable cut a period");

  a_idle_level: assert property (
    !st_reg.active[0] && $stable(st_reg.cfg.dis_high[0]) && !$past(st_reg.active[0])
    |-> clock_output_true_o[0] == st_reg.cfg.dis_high[0])
    else $error("wrong disabled level");

  a_se_phase: assert property (
    (st_reg.cfg.se_mode[0] && $stable(st_reg.cfg.se_mode[0]) && $stable(st_reg.cfg.se_inv[0]))
    |-> clock_output_complement_o[0] == (clock_output_true_o[0] ^ st_reg.cfg.se_inv[0]))
    else $error("single-ended pair polarity wrong");

  a_nvm_limit: assert property (
    st_reg.nvm_cnt == `CEO_NVM_SLOTS |=> st_reg.nvm_cnt == `CEO_NVM_SLOTS &&
    $stable(st_reg.nvm))
    else $error("NVM written beyond two");

  a_drive_valid: assert property (
    st_reg.cfg.drive[1:0] != 2'h0)
    else $error("drive code zero accepted");

  // Unmapped pins one and two have no say; an enabled output starts at its edge
  a_enable_at_edge: assert property (
    (st_reg.seq == CEO_RUN && st_reg.cfg.map1 == 7'h00 && st_reg.cfg.map2 == 7'h00 &&
     st_reg.cfg.map0[2] && !enable_pin_zero_n_i && st_reg.cfg.out_en[2] &&
     !st_reg.cfg.pd.out_pd[2] && !crystal_signal_loss_i && !st_reg.cfg.lol_dis &&
     st_reg.cnt[2] == 8'h00 && !st_reg.phase[2]) |=> st_reg.active[2])
    else $error("enabled output did not start");

  // Asynchronous mode drops the driver to its idle level on the next edge
  a_async_stop: assert property (
    (st_reg.seq == CEO_RUN && !st_reg.cfg.sync_dis[1] && st_reg.cfg.map0[1] &&
     enable_pin_zero_n_i) |=> !st_reg.active[1] &&
    clock_output_true_o[1] == $past(st_reg.cfg.dis_high[1]))
    else $error("async disable did not stop at once");

  // A powered-down driver is never switched on at a period edge
  a_pd_forces_off: assert property (
    (st_reg.seq == CEO_RUN && st_reg.cfg.pd.out_pd[0] && st_reg.cnt[0] == 8'h00 &&
     !st_reg.phase[0]) |=> !st_reg.active[0])
    else $error("powered-down output turned on");

  // Load takes the newest image: a count of one or two selects slot 0 or 1
  a_load_newest: assert property (
    (st_reg.seq == CEO_LOAD && st_reg.nvm_cnt != 2'h0) |=>
    st_reg.cfg == $past(st_reg.nvm[st_reg.nvm_cnt[1]]))
    else $error("load did not take newest image");

  // Differential drivers keep the complement opposite the true pin, from reset on
  a_diff_comp: assert property (
    (!st_reg.cfg.se_mode[0] && $stable(st_reg.cfg.se_mode[0])) |->
    clock_output_complement_o[0] == !clock_output_true_o[0])
    else $error("differential pair not complementary");

endmodule // ceo_output_enable

/* sim/ceo_board_model.sv */
// Board enable-pin logic and downstream clock receivers of the output enable block
`timescale 1ns/1ps

module ceo_board_model (
  input wire logic clk_i,
  input wire logic [2:0] en_req_i,
  input wire logic [6:0] clk_true_i,
  input wire logic [7:0] half_i,
  output logic [2:0] pin_n_o,
  output int runt_o
);
  int len [7];

  // ==========================================================
  // Enable pins
  // Board pulls a pin low to enable its outputs, high to disable them
  assign pin_n_o = ~en_req_i;

  // ==========================================================
  // Receivers
  // A high pulse shorter than half a period would upset a downstream divider
  initial runt_o = 0;
  // Count lands by non-blocking update so the bench never races it
  always @(posedge clk_i) begin
    int c;
    c = runt_o;
    for (int k = 0; k < 7; k++) begin
      if (clk_true_i[k] === 1'b1) begin
        len[k]++;
      end else begin
        if (len[k] != 0 && len[k] < half_i) begin
          c++;
        end
        len[k] = 0;
      end
    end
    runt_o <= c;
  end
endmodule // ceo_board_model

/* sim/test_clock_output_enable_control.sv */
// Self-checking bench of the clock output enable control block
`timescale 1ns/1ps

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module test_clock_output_enable_control;
  import ceo_pkg::*;
  typedef struct packed {logic [2:0] k; logic [31:0] v;} ceo_note_t;
  localparam logic [7:0] DH = 8'h02;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  ceo_bus_req_t bus = '0;
  logic [31:0] reg_rdata_o;
  logic [2:0] pin_n;
  logic [2:0] en_req = 3'b001;
  logic [2:0] ll = 3'h0;
  logic xl = 1'b0;
  logic dev_rst_n = 1'b1;
  logic i2c = 1'b0;
  logic [6:0] ck_t, ck_c;
  logic [13:0] drv;
  ceo_pd_t pd;
  logic i2c_o, spi3_o, rdy;
  logic rd_d = 1'b0;
  logic [2:0] smp = 3'h0;
  logic [1:0] nv = 2'h0;
  ceo_note_t q[$];
  ceo_note_t n;
  logic [31:0] got;
  int bad_count = 0, comparisons = 0, cyc = 0, runt, r0, i;
  // Address and reset value of every register except status, plus one unmapped place
  logic [39:0] tbl [14] = '{40'h000000007f, 40'h0400000000, 40'h0800000000,
    40'h0c0000007f, 40'h1000000000, 40'h140000007f, 40'h1800000000, 40'h1c00000000,
    40'h2000003fff, 40'h2400000000, 40'h2800000000, 40'h2c00000000, {8'h34, 24'h0, DH},
    40'h3c00000000};

  // ==========================================================
  // Clock, design and board
  always #4 clk_sys_i = ~clk_sys_i;

  ceo_output_enable #(.DIV_HALF_DEF(DH)) ceo_output_enable_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus), .reg_rdata_o(reg_rdata_o),
    .enable_pin_zero_n_i(pin_n[0]), .enable_pin_one_n_i(pin_n[1]),
    .enable_pin_two_n_i(pin_n[2]), .lock_lost_i(ll), .crystal_signal_loss_i(xl),
    .device_reset_pin_n_i(dev_rst_n), .serial_if_select_i(i2c),
    .clock_output_true_o(ck_t), .clock_output_complement_o(ck_c),
    .single_ended_drive_select_o(drv), .power_down_o(pd), .i2c_selected_o(i2c_o),
    .spi_three_wire_o(spi3_o), .config_ready_o(rdy));

  ceo_board_model ceo_board_model_i (.clk_i(clk_sys_i), .en_req_i(en_req),
    .clk_true_i(ck_t), .half_i(DH), .pin_n_o(pin_n), .runt_o(runt));

  // ==========================================================
  // Bus cycles and helpers
  function automatic logic [31:0] st(input logic [6:0] a);
    return {11'h0, i2c, 2'h0, nv, 3'h0, xl, 1'b0, ll, 1'b0, a};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    q.push_back('{3'd0, e});
    @(posedge clk_sys_i);
  endtask

  task automatic idle(input int c);
    bus <= '0;
    repeat (c) @(posedge clk_sys_i);
  endtask

  // Kinds: 1 true, 2 true xor comp, 3 drive, 4 power down, 5 status pins, 6 aligned, 7 runts
  task automatic look(input logic [2:0] k, input logic [31:0] e);
    bus <= '0;
    smp <= k;
    q.push_back('{k, e});
    @(posedge clk_sys_i);
    smp <= 3'd0;
    @(posedge clk_sys_i);
  endtask

  task automatic wait_rdy;
    idle(3);
    for (int j = 0; j < 50 && rdy !== 1'b1; j++) @(posedge clk_sys_i);
    look(3'd5, 32'h4);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watcher: takes the oldest note whenever read data or a look is due
  always @(posedge clk_sys_i) begin
    rd_d <= bus.rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end

  // Sampled mid-cycle so registered outputs have settled
  always @(negedge clk_sys_i) begin
    if (rd_d) begin
      n = q.pop_front();
      `CHK(reg_rdata_o, n.v)
    end
    if (smp != 3'd0) begin
      n = q.pop_front();
      case (smp)
        3'd1: got = 32'(ck_t);
        3'd2: got = 32'(ck_t ^ ck_c);
        3'd3: got = 32'(drv);
        3'd4: got = 32'(pd);
        3'd5: got = 32'({rdy, spi3_o, i2c_o});
        3'd7: got = 32'(runt);
        default: got = 32'(ck_t === 7'h00 || ck_t === 7'h7f);
      endcase
      `CHK(got, n.v)
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'ha890));
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    wait_rdy();
    foreach (tbl[j]) rd(tbl[j][39:32], tbl[j][31:0]);
    for (i = 0; i < 4; i++) begin
      r0 = $urandom;
      wr(8'h00, r0);
      rd(8'h00, {25'h0, r0[6:0]});
    end
    wr(8'h00, 32'h7f);
    idle(12);
    rd(8'h30, st(7'h7f));
    $display("test reset values done");
    wr(8'h14, 32'h0);
    wr(8'h30, '1);
    en_req <= 3'b000;
    idle(12);
    rd(8'h30, st(7'h00));
    en_req <= 3'b001;
    wr(8'h04, 32'h07);
    wr(8'h08, 32'h40);
    idle(12);
    rd(8'h30, st(7'h38));
    en_req <= 3'b111;
    idle(12);
    rd(8'h30, st(7'h7f));
    wr(8'h0c, 32'h77);
    idle(12);
    rd(8'h30, st(7'h77));
    wr(8'h0c, 32'h7f);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    $display("test pin control done");
    ll <= 3'b001;
    idle(12);
    rd(8'h30, st(7'h7f));
    wr(8'h28, 32'h1);
    idle(12);
    rd(8'h30, st(7'h00));
    wr(8'h24, 32'h3ffc);
    idle(12);
    rd(8'h30, st(7'h7e));
    ll <= 3'b000;
    wr(8'h28, 32'h0);
    wr(8'h24, 32'h0);
    xl <= 1'b1;
    idle(12);
    rd(8'h30, st(7'h00));
    wr(8'h28, 32'h2);
    idle(12);
    rd(8'h30, st(7'h7f));
    xl <= 1'b0;
    wr(8'h28, 32'h0);
    wr(8'h14, 32'h7f);
    $display("test fault disable done");
    wr(8'h10, 32'h7f);
    en_req <= 3'b000;
    idle(12);
    look(3'd1, 32'h7f);
    look(3'd2, 32'h7f);
    wr(8'h10, 32'h0);
    idle(2);
    look(3'd1, 32'h0);
    en_req <= 3'b001;
    wr(8'h18, 32'h7f);
    idle(12);
    look(3'd2, 32'h0);
    wr(8'h1c, 32'h55);
    idle(2);
    look(3'd2, 32'h55);
    wr(8'h18, 32'h0);
    wr(8'h1c, 32'h0);
    wr(8'h20, 32'h06d8);
    rd(8'h20, 32'h36db);
    look(3'd3, 32'h36db);
    wr(8'h2c, 32'h7301);
    idle(12);
    look(3'd4, 32'({7'h01, 3'h3, 3'h7}));
    rd(8'h30, st(7'h7e));
    wr(8'h2c, 32'h0);
    i2c <= 1'b1;
    wr(8'h28, 32'h10);
    idle(2);
    look(3'd5, 32'h7);
    rd(8'h28, 32'h10);
    wr(8'h28, 32'h0);
    i2c <= 1'b0;
    idle(2);
    look(3'd5, 32'h4);
    $display("test driver settings done");
    // First four passes synchronous, last four asynchronous, at random clock phases
    for (i = 0; i < 8; i++) begin
      wr(8'h14, i < 4 ? 32'h7f : 32'h0);
      idle($urandom_range(7, 0) + 1);
      r0 = runt;
      en_req <= 3'b000;
      idle(3);
      if (i >= 4) look(3'd1, 32'h0);
      idle(8);
      if (i < 4) look(3'd7, r0);
      look(3'd1, 32'h0);
      en_req <= 3'b001;
      idle(12);
    end
    wr(8'h14, 32'h7f);
    $display("test disable modes done");
    wr(8'h04, 32'h55);
    wr(8'h28, 32'h8);
    nv = 2'h1;
    wr(8'h04, 32'h11);
    rd(8'h04, 32'h11);
    dev_rst_n <= 1'b0;
    idle(3);
    dev_rst_n <= 1'b1;
    wait_rdy();
    rd(8'h04, 32'h55);
    wr(8'h04, 32'h22);
    wr(8'h28, 32'h8);
    nv = 2'h2;
    wr(8'h04, 32'h33);
    wr(8'h28, 32'h8);
    en_req <= 3'b011;
    wr(8'h28, 32'h4);
    wait_rdy();
    idle(12);
    rd(8'h04, 32'h22);
    rd(8'h30, st(7'h7f));
    look(3'd6, 32'h1);
    wr(8'h34, 32'h3);
    rd(8'h34, 32'h3);
    idle(2);
    $display("test nvm reload done");
    close_out();
  end
endmodule // test_clock_output_enable_control
